// ==== core/uhc_command.sv ====
`timescale 1ns/10ps
module uhc_command
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic parkCapability,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   input wire logic asyncAdvance,
   input wire logic scheduleIdle,
   output logic runSchedules,
   output logic asyncEnabled,
   output logic periodicEnabled,
   output logic [1:0] parkModeCount,
   output logic parkModeEnable,
   output logic lightResetPulse,
   output logic fullResetPulse,
   output logic interruptReq
);
   import uhc_pkg::*;
   // ********************************
   // State
   // ********************************
   typedef struct packed
   {
      logic [7:0] rateLimit;
      logic parkEn;
      logic [1:0] parkCnt;
      logic lightRst;
      logic doorbell;
      logic asyncEn;
      logic periodicEn;
      logic fullRst;
      logic runStop;
      logic halted;
      logic advanceSts;
      uhc_rst_t rstState;
      logic [3:0] rstCnt;
      logic strapDone;
      logic [31:0] rdata;
      logic lightPulse;
      logic fullPulse;
      logic asyncOn;
      logic periodicOn;
   } uhc_cmd_t;
   uhc_cmd_t st_r;
   uhc_cmd_t st_nxt;
   uhc_rate_if rate ();
   logic [31:0] cmdView;
   logic [31:0] stsView;
   logic cmdWr;
   logic stsWr;
   // ********************************
   // Register views
   // ********************************
   always_comb
   begin
      cmdView = '0;
      cmdView[UHC_CMD_RATE_HI:UHC_CMD_RATE_LO] = st_r.rateLimit;
      cmdView[UHC_CMD_PARKEN] = st_r.parkEn;
      cmdView[UHC_CMD_PARKCNT_HI:UHC_CMD_PARKCNT_LO] = st_r.parkCnt;
      cmdView[UHC_CMD_LIGHTRST] = st_r.lightRst;
      cmdView[UHC_CMD_DOORBELL] = st_r.doorbell;
      cmdView[UHC_CMD_ASYNC] = st_r.asyncEn;
      cmdView[UHC_CMD_PERIODIC] = st_r.periodicEn;
      cmdView[UHC_CMD_FULLRST] = st_r.fullRst;
      cmdView[UHC_CMD_RUN] = st_r.runStop;
      stsView = '0;
      stsView[UHC_STS_HALTED] = st_r.halted;
      stsView[UHC_STS_ADVANCE] = st_r.advanceSts;
   end
   assign cmdWr = regWrite && regAddr == UHC_OFS_COMMAND;
   assign stsWr = regWrite && regAddr == UHC_OFS_STATUS;
   // ********************************
   // Next state
   // ********************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.lightPulse = 1'b0;
      st_nxt.fullPulse = 1'b0;
      // Park defaults follow the strap once, just after reset release
      if (!st_r.strapDone)
      begin
         st_nxt.strapDone = 1'b1;
         st_nxt.parkEn = parkCapability;
         st_nxt.parkCnt = parkCapability ? UHC_PARKCNT_DEF : 2'h0;
      end
      if (regRead)
      begin
         if (regAddr == UHC_OFS_COMMAND)
         begin
            st_nxt.rdata = cmdView;
         end
         else if (regAddr == UHC_OFS_STATUS)
         begin
            st_nxt.rdata = stsView;
         end
         else
         begin
            st_nxt.rdata = '0;
         end
      end
      if (cmdWr && st_r.rstState == UHC_IDLE)
      begin
         st_nxt.rateLimit = regWdata[UHC_CMD_RATE_HI:UHC_CMD_RATE_LO];
         if (parkCapability && st_r.strapDone)
         begin
            st_nxt.parkEn = regWdata[UHC_CMD_PARKEN];
            st_nxt.parkCnt =
               regWdata[UHC_CMD_PARKCNT_HI:UHC_CMD_PARKCNT_LO];
         end
         st_nxt.asyncEn = regWdata[UHC_CMD_ASYNC];
         st_nxt.periodicEn = regWdata[UHC_CMD_PERIODIC];
         st_nxt.runStop = regWdata[UHC_CMD_RUN];
         if (regWdata[UHC_CMD_DOORBELL])
         begin
            st_nxt.doorbell = 1'b1;
         end
         if (regWdata[UHC_CMD_FULLRST])
         begin
            st_nxt.fullRst = 1'b1;
            st_nxt.rstState = UHC_FULL;
            st_nxt.rstCnt = UHC_RESET_CYCLES;
            st_nxt.fullPulse = 1'b1;
         end
         else if (regWdata[UHC_CMD_LIGHTRST])
         begin
            st_nxt.lightRst = 1'b1;
            st_nxt.rstState = UHC_LIGHT;
            st_nxt.rstCnt = UHC_RESET_CYCLES;
            st_nxt.lightPulse = 1'b1;
         end
      end
      if (stsWr && regWdata[UHC_STS_ADVANCE])
      begin
         st_nxt.advanceSts = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (asyncAdvance && st_r.doorbell && st_r.asyncEn && st_r.runStop)
      begin
         st_nxt.doorbell = 1'b0;
         st_nxt.advanceSts = 1'b1;
      end
      // Halted clears as soon as run-stop is set, but sets only once the engine has gone idle or a soft reset completes
      if (st_nxt.runStop)
      begin
         st_nxt.halted = 1'b0;
      end
      else if (scheduleIdle)
      begin
         st_nxt.halted = 1'b1;
      end
      case (st_r.rstState)
         UHC_IDLE:
         begin
         end
         UHC_FULL, UHC_LIGHT:
         begin
            if (st_r.rstCnt != 4'h0)
            begin
               st_nxt.rstCnt = st_r.rstCnt - 4'h1;
            end
            else
            begin
               // Reset complete: operational state returns to defaults
               st_nxt.rateLimit = UHC_RATE_DEF;
               st_nxt.parkEn = parkCapability;
               st_nxt.parkCnt = parkCapability ? UHC_PARKCNT_DEF : 2'h0;
               st_nxt.lightRst = 1'b0;
               st_nxt.doorbell = 1'b0;
               st_nxt.asyncEn = 1'b0;
               st_nxt.periodicEn = 1'b0;
               st_nxt.runStop = 1'b0;
               st_nxt.halted = 1'b1;
               st_nxt.advanceSts = 1'b0;
               st_nxt.fullRst = 1'b0;
               st_nxt.rstState = UHC_IDLE;
            end
         end
         default:
         begin
            st_nxt.rstState = UHC_IDLE;
         end
      endcase
      // Registered so the schedule gates leave the block from a flop
      st_nxt.asyncOn = st_nxt.asyncEn && st_nxt.runStop;
      st_nxt.periodicOn = st_nxt.periodicEn && st_nxt.runStop;
   end
   // ********************************
   // Registers
   // ********************************
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
         st_r.rateLimit <=
            UHC_CMD_RESET[UHC_CMD_RATE_HI:UHC_CMD_RATE_LO];
         st_r.halted <= UHC_STS_RESET[UHC_STS_HALTED];
         st_r.rstState <= UHC_IDLE;
      end
      else if (clkEn)
      begin
         st_r <= st_nxt;
      end
   end
   // ********************************
   // Interrupt pacing
   // ********************************
   assign rate.limit = st_r.rateLimit;
   assign rate.event_in = st_nxt.advanceSts && !st_r.advanceSts;
   assign rate.clear = st_r.rstState != UHC_IDLE;
   uhc_rate_pacer pacer
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clkEn(clkEn),
      .rate(rate.pacer)
   );
   // ********************************
   // Outputs
   // ********************************
   assign regRdata = st_r.rdata;
   assign runSchedules = st_r.runStop;
   assign asyncEnabled = st_r.asyncOn;
   assign periodicEnabled = st_r.periodicOn;
   assign parkModeCount = st_r.parkCnt;
   assign parkModeEnable = st_r.parkEn;
   assign lightResetPulse = st_r.lightPulse;
   assign fullResetPulse = st_r.fullPulse;
   assign interruptReq = rate.irq;
endmodule

// ==== core/uhc_pkg.sv ====
package uhc_pkg;
   // ********************************
   // Register map
   // ********************************
   localparam logic [7:0] UHC_OFS_COMMAND = 8'h20;
   localparam logic [7:0] UHC_OFS_STATUS = 8'h24;
   localparam logic [31:0] UHC_CMD_RESET = 32'h0008_0000;
   localparam logic [31:0] UHC_STS_RESET = 32'h0000_1000;
   // ********************************
   // Command fields
   // ********************************
   localparam int UHC_CMD_RUN = 0;
   localparam int UHC_CMD_FULLRST = 1;
   localparam int UHC_CMD_PERIODIC = 4;
   localparam int UHC_CMD_ASYNC = 5;
   localparam int UHC_CMD_DOORBELL = 6;
   localparam int UHC_CMD_LIGHTRST = 7;
   localparam int UHC_CMD_PARKCNT_LO = 8;
   localparam int UHC_CMD_PARKCNT_HI = 9;
   localparam int UHC_CMD_PARKEN = 11;
   localparam int UHC_CMD_RATE_LO = 16;
   localparam int UHC_CMD_RATE_HI = 23;
   localparam logic [1:0] UHC_PARKCNT_DEF = 2'h3;
   localparam logic [7:0] UHC_RATE_DEF = 8'h08;
   // ********************************
   // Status fields
   // ********************************
   localparam int UHC_STS_ADVANCE = 5;
   localparam int UHC_STS_HALTED = 12;
   // Countdown loaded for a full or light reset; the sequence lasts one cycle more than this
   localparam logic [3:0] UHC_RESET_CYCLES = 4'h8;
   localparam logic [7:0] UHC_MAX_RATE = 8'hff;
   typedef enum {UHC_IDLE, UHC_FULL, UHC_LIGHT} uhc_rst_t;
endpackage

// ==== core/uhc_rate_if.sv ====
`timescale 1ns/10ps
interface uhc_rate_if;
   logic [7:0] limit;
   logic event_in;
   logic clear;
   logic irq;
   modport ctrl (output limit, output event_in, output clear, input irq);
   modport pacer (input limit, input event_in, input clear, output irq);
endinterface

// ==== core/uhc_rate_pacer.sv ====
`timescale 1ns/10ps
module uhc_rate_pacer
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clkEn,
   uhc_rate_if.pacer rate
);
   import uhc_pkg::*;
   // ********************************
   // State
   // ********************************
   typedef struct packed
   {
      logic [7:0] gap;
      logic pend;
      logic irq;
   } uhc_pace_t;
   uhc_pace_t st_r;
   uhc_pace_t st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.irq = 1'b0;
      if (st_r.gap != 8'h00)
      begin
         st_nxt.gap = st_r.gap - 8'h01;
      end
      if (rate.event_in)
      begin
         st_nxt.pend = 1'b1;
      end
      // Events arriving while the gap is still counting down are merged into one interrupt
      if ((st_r.pend || rate.event_in) && st_r.gap == 8'h00)
      begin
         st_nxt.irq = 1'b1;
         st_nxt.pend = 1'b0;
         st_nxt.gap = rate.limit;
      end
      if (rate.clear)
      begin
         st_nxt = '0;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else if (clkEn)
      begin
         st_r <= st_nxt;
      end
   end
   assign rate.irq = st_r.irq;
endmodule

// ==== tb/uhc_command_sva.sv ====
`timescale 1ns/10ps
// ****
// Command checker
// ****
module uhc_command_sva
import uhc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic parkCapability,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic asyncAdvance,
   input wire logic scheduleIdle,
   input wire logic runSchedules,
   input wire logic asyncEnabled,
   input wire logic periodicEnabled,
   input wire logic [1:0] parkModeCount,
   input wire logic parkModeEnable,
   input wire logic lightResetPulse,
   input wire logic fullResetPulse,
   input wire logic interruptReq
);
   logic cmdWr;
   logic cmdRd;
   logic [3:0] busyCnt_r;
   assign cmdWr = clkEn && regWrite && regAddr == UHC_OFS_COMMAND;
   assign cmdRd = clkEn && regRead && regAddr == UHC_OFS_COMMAND;
   // Command writes are ignored while a soft reset runs, so track that window
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
         busyCnt_r <= 4'h0;
      else if (clkEn && busyCnt_r != 4'h0)
         busyCnt_r <= busyCnt_r - 4'h1;
      else if (cmdWr && (regWdata[1] || regWdata[7]))
         busyCnt_r <= UHC_RESET_CYCLES + 4'h1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   run_follow_a: assert property (cmdWr && busyCnt_r == 4'h0
      && !regWdata[1] && !regWdata[7] |=> runSchedules == $past(regWdata[0]))
      else $error("run flag not taken");
   async_gate_a: assert property (asyncEnabled |-> runSchedules)
      else $error("async enabled while stopped");
   periodic_gate_a: assert property (periodicEnabled |-> runSchedules)
      else $error("periodic enabled while stopped");
   full_start_a: assert property (cmdWr && busyCnt_r == 4'h0
      && regWdata[1] |-> ##[1:2] fullResetPulse)
      else $error("full reset not started");
   light_start_a: assert property (cmdWr && busyCnt_r == 4'h0
      && regWdata[7] && !regWdata[1] |-> ##[1:2] lightResetPulse)
      else $error("no light reset");
   pulse_once_a: assert property (clkEn && (fullResetPulse
      || lightResetPulse) |=> !fullResetPulse && !lightResetPulse)
      else $error("reset pulse long");
   rsvd_zero_a: assert property (cmdRd |=> regRdata[31:24] == 8'h00
      && regRdata[15:12] == 4'h0 && !regRdata[10] && regRdata[3:2] == 2'h0)
      else $error("reserved bits set");
   halt_run_a: assert property (clkEn && regRead
      && regAddr == UHC_OFS_STATUS && runSchedules |=> !regRdata[12])
      else $error("halted while running");
   park_echo_a: assert property (cmdRd && !regWrite |=>
      regRdata[11] == $past(parkModeEnable)
      && regRdata[9:8] == $past(parkModeCount))
      else $error("park fields differ");
   cover property (interruptReq);
   cover property (fullResetPulse);
   cover property (lightResetPulse);
endmodule
bind uhc_command uhc_command_sva chk (.*);

// ==== tb/uhc_engine_model.sv ====
`timescale 1ns/10ps
// ****
// Schedule engine model
// ****
module uhc_engine_model
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic runSchedules,
   input wire logic asyncEnabled,
   input wire logic slow,
   output logic asyncAdvance,
   output logic scheduleIdle
);
   logic [3:0] gap_r;
   logic [1:0] stop_r;
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
      begin
         gap_r <= 4'h0;
         stop_r <= 2'h0;
         asyncAdvance <= 1'b0;
         scheduleIdle <= 1'b1;
      end
      else
      begin
         // Advance only walks an enabled async schedule; slow mode delays the first advance by 11 cycles
         gap_r <= asyncEnabled ? gap_r + 4'h1 : 4'h0;
         asyncAdvance <= asyncEnabled && gap_r == (slow ? 4'hc : 4'h1);
         // Idle lags the stop by three cycles, like a transfer in flight
         stop_r <= {stop_r[0], runSchedules};
         scheduleIdle <= !runSchedules && stop_r == 2'h0;
      end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   import uhc_pkg::*;
   logic clk_sys = 1'b0, resetn = 1'b0, clkEn = 1'b1, parkCapability = 1'b1;
   logic regWrite = 1'b0, regRead = 1'b0, slow = 1'b0, seen;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000, regRdata, rd, w;
   logic asyncAdvance, scheduleIdle, runSchedules, asyncEnabled;
   logic periodicEnabled, parkModeEnable, lightResetPulse, fullResetPulse;
   logic interruptReq;
   logic [1:0] parkModeCount;
   time t0;
   int errorCnt = 0, totalChecks = 0;
   uhc_command dut (.*);
   uhc_engine_model partner (.*);
   always #10 clk_sys = ~clk_sys;
   function automatic logic [31:0] expCmd(input logic [31:0] d, input logic c);
      return (d & 32'h00ff_0031) | (c ? d & 32'h0000_0b00 : 32'h0000_0000);
   endfunction
   task conclude;
      if (errorCnt == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task rdreg(input logic [7:0] a);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      rd = regRdata;
   endtask
   // Bounded wait for a one-cycle pulse
   task waitSig(input int sel);
      seen = 1'b0;
      for (int i = 0; i < 300 && !seen; i++)
      begin
         @(negedge clk_sys);
         seen = sel == 0 ? interruptReq : sel == 1 ? fullResetPulse
            : lightResetPulse;
      end
      chk({31'h0, seen}, 32'h0000_0001);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errorCnt++;
      conclude();
   end
   initial
   begin
      void'($urandom(33884));
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({31'h0, parkModeEnable}, 32'h0000_0001);
      chk({30'h0, parkModeCount}, {30'h0, UHC_PARKCNT_DEF});
      rdreg(UHC_OFS_COMMAND);
      chk(rd, UHC_CMD_RESET | 32'h0000_0b00);
      rdreg(UHC_OFS_STATUS);
      chk(rd, UHC_STS_RESET);
      rdreg(8'h30);
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 24; i++)
      begin
         w = $urandom & 32'hffff_ff3d;
         slow <= 1'($urandom);
         wr(UHC_OFS_COMMAND, w);
         rdreg(UHC_OFS_COMMAND);
         chk(rd, expCmd(w, 1'b1));
         chk({31'h0, runSchedules}, {31'h0, w[0]});
         chk({31'h0, asyncEnabled}, {31'h0, w[5] & w[0]});
         chk({31'h0, periodicEnabled}, {31'h0, w[4] & w[0]});
         rdreg(UHC_OFS_STATUS);
         chk({31'h0, rd[12] & w[0]}, 32'h0000_0000);
      end
      // A write while the clock enable is low must leave no trace
      clkEn <= 1'b0;
      wr(UHC_OFS_COMMAND, w ^ 32'h0000_0031);
      clkEn <= 1'b1;
      rdreg(UHC_OFS_COMMAND);
      chk(rd, expCmd(w, 1'b1));
      chk({31'h0, runSchedules}, {31'h0, w[0]});
      wr(UHC_OFS_COMMAND, 32'h0008_0000);
      rd = 32'h0000_0000;
      for (int i = 0; i < 20 && !rd[12]; i++)
         rdreg(UHC_OFS_STATUS);
      chk({31'h0, rd[12]}, 32'h0000_0001);
      wr(UHC_OFS_COMMAND, 32'h0008_0061);
      waitSig(0);
      rdreg(UHC_OFS_STATUS);
      chk(rd & 32'h0000_1020, 32'h0000_0020);
      wr(UHC_OFS_STATUS, 32'h0000_0020);
      rdreg(UHC_OFS_STATUS);
      chk(rd & 32'h0000_0020, 32'h0000_0000);
      // Two doorbells under the widest threshold must be paced apart
      wr(UHC_OFS_COMMAND, {8'h00, UHC_MAX_RATE, 16'h0061});
      waitSig(0);
      t0 = $time;
      wr(UHC_OFS_STATUS, 32'h0000_0020);
      wr(UHC_OFS_COMMAND, {8'h00, UHC_MAX_RATE, 16'h0061});
      waitSig(0);
      chk({31'h0, $time - t0 > UHC_MAX_RATE * 20}, 32'h0000_0001);
      wr(UHC_OFS_COMMAND, 32'h0008_0013);
      waitSig(1);
      rdreg(UHC_OFS_COMMAND);
      chk({31'h0, rd[1]}, 32'h0000_0001);
      repeat (12) @(posedge clk_sys);
      rdreg(UHC_OFS_COMMAND);
      chk(rd, 32'h0008_0b00);
      rdreg(UHC_OFS_STATUS);
      chk(rd, UHC_STS_RESET);
      @(posedge clk_sys);
      parkCapability <= 1'b0;
      wr(UHC_OFS_COMMAND, 32'h0008_0081);
      waitSig(2);
      repeat (12) @(posedge clk_sys);
      rdreg(UHC_OFS_COMMAND);
      chk(rd, UHC_CMD_RESET);
      wr(UHC_OFS_COMMAND, 32'h0008_0b01);
      rdreg(UHC_OFS_COMMAND);
      chk(rd, 32'h0008_0001);
      parkCapability <= 1'b1;
      wr(UHC_OFS_COMMAND, 32'h0008_0080);
      repeat (12) @(posedge clk_sys);
      rdreg(UHC_OFS_COMMAND);
      chk(rd, 32'h0008_0b00);
      conclude();
   end
endmodule
